// File: verification/gpio_pins_props.sv
// timing relations of the pin block, seen at its ports
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module gpio_checker import gpio_pkg::*; (
	input wire logic clk_i, // core clock
	input wire logic nrst_i, // reset, active low
	input wire logic [PIN_COUNT-1:0] pin_function_select_i, // alternate per pin
	input wire logic [PIN_COUNT-1:0] pin_direction_select_i, // output per pin
	input wire logic [PIN_COUNT-1:0] pin_alternate_select_i, // signal 1 per pin
	input wire logic [PIN_COUNT-1:0] pin_data_reg_o, // sampled levels
	input wire logic [PIN_COUNT-1:0] pad_out_o, // pad values
	input wire logic [PIN_COUNT-1:0] pad_oe_o, // pad enables
	input wire logic [PART_COUNT-1:0] partition_reset_in_n_o, // partition levels
	input wire logic [PART_COUNT-1:0] partition_reset_start_o, // start pulses
	input wire logic general_event_out_n_i, // event level
	input wire logic [PORT_COUNT-1:0] port_link_up_n_i // link up levels
);
	logic [PIN_COUNT-1:0] fn_reg;
	logic [PIN_COUNT-1:0] sw_oe_reg;
	always_ff @(posedge clk_i) begin
		fn_reg <= pin_function_select_i;
		sw_oe_reg <= pin_direction_select_i & ~pin_function_select_i;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	reset_idle_a: assert property ($rose(nrst_i) |->
		pad_oe_o == '0 && pin_data_reg_o == '1) else $error("pads not idle after reset");
	sw_direction_a: assert property ($past(nrst_i) |->
		(pad_oe_o & ~fn_reg) == sw_oe_reg) else $error("software direction wrong");
	event_drive_a: assert property (pin_function_select_i[5] && !pin_alternate_select_i[5] |=>
		pad_oe_o[5] && pad_out_o[5] == $past(general_event_out_n_i)) else $error("event pin wrong");
	link_up_a: assert property (pin_function_select_i[4] && pin_alternate_select_i[4] |=>
		pad_oe_o[4] && pad_out_o[4] == $past(port_link_up_n_i[0])) else $error("link pin wrong");
	alt_input_a: assert property (&pin_function_select_i[3:0] |=> pad_oe_o[3:0] == 4'h0)
		else $error("alternate input pin driven");
	unmapped_reset_a: assert property (!pin_function_select_i[0] [*2] |=>
		partition_reset_in_n_o[0]) else $error("unmapped reset not high");
	reset_start_a: assert property (partition_reset_start_o ==
		($past(partition_reset_in_n_o) & ~partition_reset_in_n_o)) else $error("start pulse wrong");
	sample_rate_a: assert property ($changed(pin_data_reg_o) |=>
		$stable(pin_data_reg_o) [*3]) else $error("sampled too often");
	cover property (partition_reset_start_o != 4'h0);
	cover property ($changed(pin_data_reg_o));
	cover property (pad_oe_o[5] && pad_oe_o[4]);
endmodule // gpio_checker
bind gpio_pins gpio_checker i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.pin_function_select_i(pin_function_select_i), .pin_direction_select_i(pin_direction_select_i),
	.pin_alternate_select_i(pin_alternate_select_i), .pin_data_reg_o(pin_data_reg_o),
	.pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .partition_reset_in_n_o(partition_reset_in_n_o),
	.partition_reset_start_o(partition_reset_start_o),
	.general_event_out_n_i(general_event_out_n_i), .port_link_up_n_i(port_link_up_n_i));

// File: verification/gpio_pins_tb_top.sv
// self-checking bench for the pin block
// assumes the board model closes the loop from pad drivers to pad inputs
`timescale 1ns/1ps
module gpio_pins_tb_top import gpio_pkg::*; ;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic wr = 1'b0;
	logic evt_n = 1'b1;
	logic [PIN_COUNT-1:0] func = '0, dir = '0, alt = '0, wdata = '0, drive = 32'h1234_ABCF;
	logic [PIN_COUNT-1:0] pad_out, pad_oe, pad_in, rdata;
	logic [PART_COUNT-1:0] prst_n, pstart;
	logic irq_n;
	logic [SLOT_GROUPS-1:0] xen = '0, attn_n = 3'h3, pled_n = 3'h0, pen = 3'h1, srst_n = 3'h2;
	logic [SLOT_GROUPS-1:0] btn_n, pgd_n, pres_n, pflt_n, latch_n;
	logic [SLOT_GROUPS*SLOT_INPUTS-1:0] xin_n = '1;
	logic [PORT_COUNT-1:0] lup_n = 6'h3D, lact_n = 6'h15;
	int n_mismatch = 0;
	int checks_done = 0;
	initial forever #20 clk_i = ~clk_i;
	gpio_pins i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .pin_function_select_i(func),
		.pin_direction_select_i(dir), .pin_alternate_select_i(alt), .pin_data_write_i(wr),
		.pin_data_wdata_i(wdata), .pin_data_reg_o(rdata), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe), .partition_reset_in_n_o(prst_n),
		.partition_reset_start_o(pstart), .expander_irq_in_n_o(irq_n),
		.general_event_out_n_i(evt_n), .expander_slot_en_i(xen), .expander_slot_in_n_i(xin_n),
		.slot_button_in_n_o(btn_n), .slot_presence_in_n_o(pres_n),
		.slot_power_fault_in_n_o(pflt_n), .slot_power_good_in_n_o(pgd_n),
		.slot_latch_in_n_o(latch_n), .slot_attention_led_n_i(attn_n),
		.slot_power_led_n_i(pled_n), .slot_power_enable_i(pen), .slot_reset_out_n_i(srst_n),
		.port_link_up_n_i(lup_n), .port_link_active_n_i(lact_n));
	pad_board i_board (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .drive_i(drive), .level_o(pad_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// sampling latency is at most 8 cycles, so 10 leaves margin
	task automatic settle();
		repeat (10) @(posedge clk_i);
		#1;
	endtask
	task automatic t_reset();
		chk(pad_oe, 32'h0);
		chk(prst_n, 4'hF);
		settle();
		chk(rdata, 32'h1234_ABCF);
		$display("test reset done");
	endtask
	task automatic t_output();
		@(posedge clk_i);
		dir <= 32'h0000_FFFF;
		wr <= 1'b1;
		wdata <= 32'h0000_1111;
		@(posedge clk_i);
		wdata <= 32'h0000_5A3C;
		@(posedge clk_i);
		wr <= 1'b0;
		settle();
		chk(pad_oe, 32'h0000_FFFF);
		chk(pad_out[15:0], 16'h5A3C);
		chk(rdata, 32'h1234_5A3C);
		$display("test output done");
	endtask
	task automatic t_alt();
		int i;
		logic seen;
		seen = 1'b0;
		// park every pin as an input first so only partition 1 sees a falling level
		@(posedge clk_i);
		dir <= 32'h0;
		drive <= 32'hFFFF_FFFD;
		settle();
		@(posedge clk_i);
		func <= '1;
		alt <= 32'hFFC0_0010;
		evt_n <= 1'b0;
		for (i = 0; i < 20 && seen !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
			seen = (pstart === 4'h2);
		end
		chk(seen, 1'b1);
		settle();
		chk(prst_n, 4'hD);
		chk(pad_oe[3:0], 4'h0);
		chk(pad_out[5:4], 2'h1);
		chk({pad_oe[23:22], pad_out[23:22]}, 4'hC);
		chk(pad_out[17:14], 4'h5);
		chk({irq_n, btn_n[0], rdata[1]}, 3'h6);
		@(posedge clk_i);
		drive <= 32'hFFF7_DCFD;
		xen <= 3'h4;
		xin_n <= 15'h13FF;
		settle();
		chk({irq_n, btn_n[0], btn_n[2], pgd_n[2]}, 4'h0);
		chk({pres_n, pflt_n, latch_n}, 9'h07A);
		$display("test alternate done");
		if (seen !== 1'b1) final_report();
	endtask
	// swap every alternate select: slot group 1 outputs, port 0 active, pins win over expander
	task automatic t_swap();
		@(posedge clk_i);
		alt <= 32'h003F_FFEF;
		settle();
		chk(pad_oe, 32'h0780_0020);
		chk(pad_out[26:23], 4'h9);
		chk(pad_out[5], 1'b1);
		chk({prst_n, irq_n, btn_n}, 8'hFF);
		chk(rdata[26:23], 4'h9);
		$display("test swap done");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		#1;
		t_reset();
		t_output();
		t_alt();
		t_swap();
		final_report();
	end
endmodule // gpio_pins_tb_top

// File: verification/pad_board.sv
// board side of the pads: resolves each wire from both drivers
// assumes the board yields wherever the block enables its driver
`timescale 1ns/1ps
module pad_board import gpio_pkg::*; (
	input wire logic [PIN_COUNT-1:0] pad_out_i, // block drive values
	input wire logic [PIN_COUNT-1:0] pad_oe_i, // block drive enables
	input wire logic [PIN_COUNT-1:0] drive_i, // board levels
	output logic [PIN_COUNT-1:0] level_o // wire levels
);
	// combinational on purpose: board logic takes software outputs as asynchronous
	assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & drive_i);
endmodule // pad_board

// File: verilog/gpio_pins.sv
// general purpose pin block: 32 pads as software input, output or alternate signal
// assumes configuration ports come from same-clock software logic, pads are asynchronous
`timescale 1ns/1ps
module gpio_pins import gpio_pkg::*; (
	input wire logic clk_i, // core clock, 25 MHz
	input wire logic nrst_i, // fundamental reset, synchronous, active low
	input wire logic [PIN_COUNT-1:0] pin_function_select_i, // 1 = alternate signal
	input wire logic [PIN_COUNT-1:0] pin_direction_select_i, // 1 = output
	input wire logic [PIN_COUNT-1:0] pin_alternate_select_i, // alternate signal 0 or 1
	input wire logic pin_data_write_i, // write enable for output data, written on every cycle it is high
	input wire logic [PIN_COUNT-1:0] pin_data_wdata_i, // output data written
	output logic [PIN_COUNT-1:0] pin_data_reg_o, // sampled pin levels
	input wire logic [PIN_COUNT-1:0] pad_in_i, // pad input levels
	output logic [PIN_COUNT-1:0] pad_out_o, // pad output levels
	output logic [PIN_COUNT-1:0] pad_oe_o, // pad drive enables, high drives
	output logic [PART_COUNT-1:0] partition_reset_in_n_o, // partition reset levels
	output logic [PART_COUNT-1:0] partition_reset_start_o, // pulse: start partition reset
	output logic expander_irq_in_n_o, // expander interrupt level
	input wire logic general_event_out_n_i, // general event from hot-plug logic
	input wire logic [SLOT_GROUPS-1:0] expander_slot_en_i, // slot group served by expander
	input wire logic [SLOT_GROUPS*SLOT_INPUTS-1:0] expander_slot_in_n_i, // expander slot inputs
	output logic [SLOT_GROUPS-1:0] slot_button_in_n_o, // attention button
	output logic [SLOT_GROUPS-1:0] slot_presence_in_n_o, // presence detect
	output logic [SLOT_GROUPS-1:0] slot_power_fault_in_n_o, // power fault
	output logic [SLOT_GROUPS-1:0] slot_power_good_in_n_o, // power good
	output logic [SLOT_GROUPS-1:0] slot_latch_in_n_o, // retention latch
	input wire logic [SLOT_GROUPS-1:0] slot_attention_led_n_i, // attention indicator
	input wire logic [SLOT_GROUPS-1:0] slot_power_led_n_i, // power indicator
	input wire logic [SLOT_GROUPS-1:0] slot_power_enable_i, // power enable
	input wire logic [SLOT_GROUPS-1:0] slot_reset_out_n_i, // slot reset
	input wire logic [PORT_COUNT-1:0] port_link_up_n_i, // per-port link up
	input wire logic [PORT_COUNT-1:0] port_link_active_n_i // per-port link active
);
	typedef struct packed {
		logic [PIN_COUNT-1:0] drive;
		logic [PIN_COUNT-1:0] sample;
		logic [PIN_COUNT-1:0] pad_out;
		logic [PIN_COUNT-1:0] pad_oe;
		logic [PART_COUNT-1:0] part_n;
		logic [PART_COUNT-1:0] part_start;
		logic irq_n;
		logic [SLOT_GROUPS*SLOT_INPUTS-1:0] slot_in_n;
	} pins_state_t;

	pins_state_t st_reg;
	pins_state_t st_next;
	logic [PIN_COUNT-1:0] level;
	logic tick;
	logic [PIN_COUNT-1:0] alt_oe;
	logic [PIN_COUNT-1:0] alt_val;
	logic [PIN_COUNT-1:0] alt_in;

	pin_sync u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(pad_in_i),
		.level_o(level)
	);

	sample_tick u_tick (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.tick_o(tick)
	);

	// alternate signal map: which pins drive, with what, and which carry an input
	always_comb begin
		int g;
		int j;
		int k;
		g = 0;
		j = 0;
		k = 0;
		alt_oe = PIN_LOW_RST;
		alt_val = PIN_HIGH_RST;
		alt_in = PIN_LOW_RST;
		for (int p = 0; p < PIN_COUNT; p++) begin
			g = (p - PIN_SLOT_BASE) / SLOT_PINS;
			j = (p - PIN_SLOT_BASE) % SLOT_PINS;
			k = (p - PIN_LINK_BASE) / 2 + 1;
			if (!pin_alternate_select_i[p]) begin
				if (p < PART_COUNT || p == PIN_EXP_IRQ) begin
					alt_in[p] = 1'b1;
				end else if (p == PIN_EVENT) begin
					alt_oe[p] = 1'b1;
					alt_val[p] = general_event_out_n_i;
				end else if (p >= PIN_SLOT_BASE) begin
					case (j)
						SLOT_ATTN: begin
							alt_oe[p] = 1'b1;
							alt_val[p] = slot_attention_led_n_i[g];
						end
						SLOT_PWR_LED: begin
							alt_oe[p] = 1'b1;
							alt_val[p] = slot_power_led_n_i[g];
						end
						SLOT_PWR_EN: begin
							alt_oe[p] = 1'b1;
							alt_val[p] = slot_power_enable_i[g];
						end
						SLOT_RST: begin
							alt_oe[p] = 1'b1;
							alt_val[p] = slot_reset_out_n_i[g];
						end
						default: begin
							alt_in[p] = 1'b1;
						end
					endcase
				end
			end else begin
				if (p == PIN_LINK_UP0) begin
					alt_oe[p] = 1'b1;
					alt_val[p] = port_link_up_n_i[0];
				end else if (p == PIN_EVENT) begin
					alt_oe[p] = 1'b1;
					alt_val[p] = port_link_active_n_i[0];
				end else if (p >= PIN_LINK_BASE) begin
					alt_oe[p] = 1'b1;
					alt_val[p] = (p % 2 == 0) ? port_link_up_n_i[k] : port_link_active_n_i[k];
				end
			end
		end
	end

	always_comb begin
		st_next = st_reg;
		// software output data; the board must treat these pads as asynchronous
		if (pin_data_write_i) begin
			st_next.drive = pin_data_wdata_i;
		end
		// every pin is sampled, so a read shows the pad whatever its mode
		if (tick) begin
			st_next.sample = level;
		end
		for (int p = 0; p < PIN_COUNT; p++) begin
			if (pin_function_select_i[p]) begin
				st_next.pad_oe[p] = alt_oe[p];
				st_next.pad_out[p] = alt_val[p];
			end else begin
				st_next.pad_oe[p] = pin_direction_select_i[p];
				st_next.pad_out[p] = st_reg.drive[p];
			end
		end
		// inputs taken neither from a pin nor, for an enabled slot group, from the expander stay inactive high
		for (int i = 0; i < PART_COUNT; i++) begin
			st_next.part_n[i] = (pin_function_select_i[i] && alt_in[i]) ? level[i] : 1'b1;
			st_next.part_start[i] = st_reg.part_n[i] && !st_next.part_n[i];
		end
		st_next.irq_n = (pin_function_select_i[PIN_EXP_IRQ] && alt_in[PIN_EXP_IRQ]) ?
			level[PIN_EXP_IRQ] : 1'b1;
		for (int g = 0; g < SLOT_GROUPS; g++) begin
			for (int j = 0; j < SLOT_INPUTS; j++) begin
				if (pin_function_select_i[PIN_SLOT_BASE + g * SLOT_PINS + j] &&
					alt_in[PIN_SLOT_BASE + g * SLOT_PINS + j]) begin
					st_next.slot_in_n[g * SLOT_INPUTS + j] =
						level[PIN_SLOT_BASE + g * SLOT_PINS + j];
				end else if (expander_slot_en_i[g]) begin
					st_next.slot_in_n[g * SLOT_INPUTS + j] =
						expander_slot_in_n_i[g * SLOT_INPUTS + j];
				end else begin
					st_next.slot_in_n[g * SLOT_INPUTS + j] = 1'b1;
				end
			end
		end
	end

	// reset leaves every pad undriven, i.e. an input
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_reg <= '{PIN_LOW_RST, PIN_HIGH_RST, PIN_HIGH_RST, PIN_LOW_RST,
				{PART_COUNT{1'b1}}, {PART_COUNT{1'b0}}, 1'b1,
				{(SLOT_GROUPS * SLOT_INPUTS){1'b1}}};
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		for (int g = 0; g < SLOT_GROUPS; g++) begin
			slot_button_in_n_o[g] = st_reg.slot_in_n[g * SLOT_INPUTS];
			slot_presence_in_n_o[g] = st_reg.slot_in_n[g * SLOT_INPUTS + 1];
			slot_power_fault_in_n_o[g] = st_reg.slot_in_n[g * SLOT_INPUTS + 2];
			slot_power_good_in_n_o[g] = st_reg.slot_in_n[g * SLOT_INPUTS + 3];
			slot_latch_in_n_o[g] = st_reg.slot_in_n[g * SLOT_INPUTS + 4];
		end
	end

	assign pin_data_reg_o = st_reg.sample;
	assign pad_out_o = st_reg.pad_out;
	assign pad_oe_o = st_reg.pad_oe;
	assign partition_reset_in_n_o = st_reg.part_n;
	assign partition_reset_start_o = st_reg.part_start;
	assign expander_irq_in_n_o = st_reg.irq_n;
endmodule // gpio_pins

// File: verilog/gpio_pkg.sv
// constants shared by the general purpose pin block and its helpers
// assumes a single 25 MHz core clock and a synchronous active-low reset
package gpio_pkg;
	localparam int PIN_COUNT = 32;
	localparam int PART_COUNT = 4;
	localparam int SLOT_GROUPS = 3;
	localparam int SLOT_INPUTS = 5;
	localparam int PORT_COUNT = 6;
	localparam int SYNC_STAGES = 3;
	// pin positions of the alternate signals
	localparam int PIN_LINK_UP0 = 4;
	localparam int PIN_EVENT = 5;
	localparam int PIN_EXP_IRQ = 8;
	localparam int PIN_SLOT_BASE = 9;
	localparam int SLOT_PINS = 9;
	localparam int PIN_LINK_BASE = 22;
	// slot signal positions inside one group
	localparam int SLOT_ATTN = 5;
	localparam int SLOT_PWR_LED = 6;
	localparam int SLOT_PWR_EN = 7;
	localparam int SLOT_RST = 8;
	// input sampling interval: least time, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 40;
	localparam int SAMPLE_NS = 128;
	localparam int SAMPLE_CYCLES = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 3;
	// values after reset
	localparam logic [PIN_COUNT-1:0] PIN_LOW_RST = 32'h0000_0000;
	localparam logic [PIN_COUNT-1:0] PIN_HIGH_RST = 32'hFFFF_FFFF;
	localparam logic [TICK_W-1:0] TICK_RST = 3'h0;
endpackage

// File: verilog/pin_sync.sv
// three-stage synchroniser bank for the asynchronous pad inputs
// assumes pads change freely with respect to clk_i
`timescale 1ns/1ps
module pin_sync import gpio_pkg::*; (
	input wire logic clk_i, // core clock
	input wire logic nrst_i, // synchronous reset, active low
	input wire logic [PIN_COUNT-1:0] async_i, // raw pad levels
	output logic [PIN_COUNT-1:0] level_o // settled pad levels
);
	typedef struct packed {
		logic [PIN_COUNT-1:0] s1;
		logic [PIN_COUNT-1:0] s2;
		logic [PIN_COUNT-1:0] s3;
		logic [PIN_COUNT-1:0] level;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// the first stage is read by the second only; a change counts once stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = async_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int b = 0; b < PIN_COUNT; b++) begin
			if (st_reg.s2[b] == st_reg.s3[b]) begin
				st_next.level[b] = st_reg.s3[b];
			end
		end
	end

	// pads idle high, so the chain starts high to avoid a false low after reset
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_reg <= '{PIN_HIGH_RST, PIN_HIGH_RST, PIN_HIGH_RST, PIN_HIGH_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_o = st_reg.level;
endmodule // pin_sync

// File: verilog/sample_tick.sv
// free-running sample interval counter
// assumes clk_i runs at the package clock period
`timescale 1ns/1ps
module sample_tick import gpio_pkg::*; (
	input wire logic clk_i, // core clock
	input wire logic nrst_i, // synchronous reset, active low
	output logic tick_o // one-cycle pulse per sample interval
);
	typedef struct packed {
		logic [TICK_W-1:0] count;
		logic tick;
	} tick_state_t;

	tick_state_t st_reg;
	tick_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.count == TICK_W'(SAMPLE_CYCLES - 1)) begin
			st_next.count = TICK_RST;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_reg <= '{TICK_RST, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
endmodule // sample_tick
